// [hw/pin_sync2.v]
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module pin_sync2 #(
    parameter WIDTH = 1
) (
    input  wire             clk_in,     // Management clock
    input  wire             rst_n_in,   // Synchronous reset, active low
    input  wire [WIDTH-1:0] async_in,   // Unsynchronised levels
    output wire [WIDTH-1:0] sync_out    // Levels after two flops
);

    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            stage1 <= {WIDTH{1'b0}};
            stage2 <= {WIDTH{1'b0}};
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
        end
    end

    assign sync_out = stage2;

endmodule // pin_sync2

// [hw/quick_poll_status.v]
// Quick poll detailed status register with receive symbol monitor
`timescale 1ns/1ps
`include "quick_poll_map.vh"

//////////////////////////////////////////////////////////////////////////////
// Contract
// - Speed bit from pin or control bit
// - Speed bit zero 10M, one 100M
// - Duplex bit from pin or control bit
// - Duplex bit zero half, one full
// - Monitor cleared on reset, disable, restart
// - Between reads and clears, monitor only rises to higher state codes
// - Monitor codes; completion shows 000
// - Read returns peak, then loads present state
// - Latch flag on receive signal loss
// - Latch flag on receive lock failure
// - Latch flag when start is not J/K
// - Symbol error drives RXER and flag
// - Halt symbol signalled and flagged
// - Two idles in packet flag premature end
// - Receive flags undefined in 10M mode
// - Complete bit only when negotiation done
// - Signal detect bit follows receive signal in 100M mode, reads zero in 10M
// - Sixteen bit read-only, reset defaults
// - Register sits at management index 0x11
module quick_poll_status (
    input  wire                  clk_in,             // Management clock
    input  wire                  rst_n_in,           // Synchronous reset, active low
    input  wire                  hw_mode_pin_in,     // Pin: high selects hardware mode
    input  wire                  rate_select_pin_in, // Pin: high selects 100M
    input  wire                  duplex_select_pin_in, // Pin: high selects full duplex
    input  wire                  signal_detect_in,   // Analog detector on receive pair
    input  wire                  ctl_speed_in,       // Control speed bit
    input  wire                  ctl_duplex_in,      // Control duplex bit
    input  wire                  ctl_aneg_enable_in, // Control negotiation enable
    input  wire                  ctl_aneg_restart_in, // Control negotiation restart
    input  wire [2:0]            aneg_state_in,      // Present arbitration state code
    input  wire                  aneg_complete_in,   // Negotiation finished, pages valid
    input  wire                  pll_locked_in,      // Receive clock recovery locked
    input  wire [4:0]            rx_symbol_in,       // Aligned receive symbol
    input  wire                  rx_symbol_valid_in, // Symbol strobe
    input  wire                  mgmt_rd_in,         // Management read strobe
    input  wire [4:0]            mgmt_addr_in,       // Management register index
    output reg  [15:0]           mgmt_rd_data_out,   // Read data
    output reg                   mgmt_rd_valid_out,  // Read data valid pulse
    output reg                   rx_error_out,       // Receive error toward MAC
    output reg                   rx_halt_out         // Halt seen, toward MAC
);

    //////////////////////////////////////////////////////////////////////////
    // States and helpers

    localparam [2:0] ST_IDLE   = 3'b001;
    localparam [2:0] ST_GOT_J  = 3'b010;
    localparam [2:0] ST_PACKET = 3'b100;

    localparam [`QP_DATA_W-1:0] READ_ZERO = `QP_RESET_VALUE;

    function is_data_code;
        input [`QP_SYM_W-1:0] sym;
        reg   [31:0]          mask;
        begin
            mask = `QP_DATA_CODE_MASK;
            is_data_code = mask[sym];
        end
    endfunction

    function is_control_code;
        input [`QP_SYM_W-1:0] sym;
        begin
            is_control_code = (sym == `QP_SYM_I) || (sym == `QP_SYM_T) ||
                              (sym == `QP_SYM_R) || (sym == `QP_SYM_H);
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers

    wire [3:0] pins_sync;
    wire       hw_mode;
    wire       rate_pin;
    wire       duplex_pin;
    wire       sig_det;

    pin_sync2 #(
        .WIDTH (4)
    ) u_pin_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .async_in ({signal_detect_in, duplex_select_pin_in,
                    rate_select_pin_in, hw_mode_pin_in}),
        .sync_out (pins_sync)
    );

    assign hw_mode    = pins_sync[0];
    assign rate_pin   = pins_sync[1];
    assign duplex_pin = pins_sync[2];
    assign sig_det    = pins_sync[3];

    //////////////////////////////////////////////////////////////////////////
    // Selected technology

    reg speed_sel;
    reg duplex_sel;
    reg sig_det_q;

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            speed_sel  <= 1'b0;
            duplex_sel <= 1'b0;
            sig_det_q  <= 1'b0;
        end
        else
        begin
            // Selection only, says nothing about link
            speed_sel  <= hw_mode ? rate_pin : ctl_speed_in;
            duplex_sel <= hw_mode ? duplex_pin : ctl_duplex_in;
            sig_det_q  <= sig_det;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Receive symbol watcher

    reg [2:0] rx_state;
    reg [2:0] next_rx_state;
    reg       last_idle;
    reg       next_last_idle;
    reg       ev_false_carr;
    reg       ev_invalid;
    reg       ev_halt;
    reg       ev_prem_end;

    // 10M mode leaves the watcher parked; its flags mean nothing there
    wire      watch = rx_symbol_valid_in & speed_sel;

    always @*
    begin
        next_rx_state  = rx_state;
        next_last_idle = last_idle;
        ev_false_carr  = 1'b0;
        ev_invalid     = 1'b0;
        ev_halt        = 1'b0;
        ev_prem_end    = 1'b0;
        if (!speed_sel)
        begin
            next_rx_state  = ST_IDLE;
            next_last_idle = 1'b0;
        end
        else if (watch)
        begin
            case (rx_state)
                ST_IDLE:
                begin
                    if (rx_symbol_in == `QP_SYM_J)
                        next_rx_state = ST_GOT_J;
                    else if (rx_symbol_in != `QP_SYM_I)
                        ev_false_carr = 1'b1;
                end
                ST_GOT_J:
                begin
                    if (rx_symbol_in == `QP_SYM_K)
                    begin
                        next_rx_state  = ST_PACKET;
                        next_last_idle = 1'b0;
                    end
                    else
                    begin
                        ev_false_carr = 1'b1;
                        next_rx_state = ST_IDLE;
                    end
                end
                ST_PACKET:
                begin
                    next_last_idle = 1'b0;
                    if (rx_symbol_in == `QP_SYM_I)
                    begin
                        if (last_idle)
                        begin
                            ev_prem_end   = 1'b1;
                            next_rx_state = ST_IDLE;
                        end
                        else
                            next_last_idle = 1'b1;
                    end
                    else if (rx_symbol_in == `QP_SYM_H)
                        ev_halt = 1'b1;
                    else if ((rx_symbol_in == `QP_SYM_T) ||
                             (rx_symbol_in == `QP_SYM_R))
                        next_rx_state = ST_IDLE;
                    else if (!is_data_code(rx_symbol_in) &&
                             !is_control_code(rx_symbol_in))
                        ev_invalid = 1'b1;
                end
                default:
                begin
                    next_rx_state  = ST_IDLE;
                    next_last_idle = 1'b0;
                end
            endcase
        end
    end

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            rx_state     <= ST_IDLE;
            last_idle    <= 1'b0;
            rx_error_out <= 1'b0;
            rx_halt_out  <= 1'b0;
        end
        else
        begin
            rx_state     <= next_rx_state;
            last_idle    <= next_last_idle;
            rx_error_out <= ev_invalid;
            rx_halt_out  <= ev_halt;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Latching-high flags

    wire                  qp_read = mgmt_rd_in && (mgmt_addr_in == `QP_REG_ADDR);
    wire [`QP_NFLAGS-1:0] flag_events;
    reg  [`QP_NFLAGS-1:0] flags;
    reg  [`QP_NFLAGS-1:0] next_flags;

    // Loss counts only on a falling detect, so a dead line flags once, not again on later reads
    assign flag_events[`QP_FL_SIG_LOST]   = speed_sel & sig_det_q & ~sig_det;
    assign flag_events[`QP_FL_LOCK_ERR]   = speed_sel & sig_det & ~pll_locked_in;
    assign flag_events[`QP_FL_FALSE_CARR] = ev_false_carr;
    assign flag_events[`QP_FL_INVALID]    = ev_invalid;
    assign flag_events[`QP_FL_HALT]       = ev_halt;
    assign flag_events[`QP_FL_PREM_END]   = ev_prem_end;

    always @*
    begin
        next_flags = flags;
        if (qp_read)
            next_flags = {`QP_NFLAGS{1'b0}};
        // New event survives the clearing read
        next_flags = next_flags | flag_events;
    end

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
            flags <= `QP_FLAGS_RESET;
        else
            flags <= next_flags;
    end

    //////////////////////////////////////////////////////////////////////////
    // Negotiation progress monitor

    reg [`QP_MON_W-1:0] monitor;
    reg [`QP_MON_W-1:0] next_monitor;
    reg                 aneg_done;

    always @*
    begin
        next_monitor = monitor;
        if (!ctl_aneg_enable_in || ctl_aneg_restart_in)
            next_monitor = `QP_MON_IDLE;
        else if (qp_read)
            next_monitor = aneg_state_in;
        else if (aneg_state_in > monitor)
            next_monitor = aneg_state_in;
    end

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            monitor   <= `QP_MON_IDLE;
            aneg_done <= 1'b0;
        end
        else
        begin
            monitor   <= next_monitor;
            aneg_done <= aneg_complete_in & ctl_aneg_enable_in &
                         ~ctl_aneg_restart_in;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Read image and answer

    reg [`QP_DATA_W-1:0] image;

    always @*
    begin
        image = READ_ZERO;
        image[`QP_BIT_SPEED]  = speed_sel;
        image[`QP_BIT_DUPLEX] = duplex_sel;
        // Finished negotiation reads as complete with a zero monitor
        image[`QP_MON_HI:`QP_MON_LO] = aneg_done ? `QP_MON_IDLE : monitor;
        image[`QP_BIT_SIG_LOST]   = flags[`QP_FL_SIG_LOST];
        image[`QP_BIT_LOCK_ERR]   = flags[`QP_FL_LOCK_ERR];
        image[`QP_BIT_FALSE_CARR] = flags[`QP_FL_FALSE_CARR];
        image[`QP_BIT_INVALID]    = flags[`QP_FL_INVALID];
        image[`QP_BIT_HALT]       = flags[`QP_FL_HALT];
        image[`QP_BIT_PREM_END]   = flags[`QP_FL_PREM_END];
        image[`QP_BIT_ANEG_DONE]  = aneg_done;
        image[`QP_BIT_SIG_DET]    = speed_sel & sig_det_q;
    end

    always @(posedge clk_in)
    begin
        if (!rst_n_in)
        begin
            mgmt_rd_data_out  <= `QP_RESET_VALUE;
            mgmt_rd_valid_out <= 1'b0;
        end
        else
        begin
            mgmt_rd_valid_out <= qp_read;
            // Old flag values leave before the clear lands
            if (qp_read)
                mgmt_rd_data_out <= image;
        end
    end

endmodule // quick_poll_status

// [pkg/quick_poll_map.vh]
// Register index, field positions and symbol codes of the quick poll status register
`ifndef QUICK_POLL_MAP_VH
`define QUICK_POLL_MAP_VH

// Management register index and geometry
`define QP_REG_ADDR        5'h11
`define QP_ADDR_W          5
`define QP_DATA_W          16
`define QP_RESET_VALUE     16'h0000

// Field positions
`define QP_BIT_SPEED       15
`define QP_BIT_DUPLEX      14
`define QP_MON_HI          13
`define QP_MON_LO          11
`define QP_BIT_SIG_LOST    10
`define QP_BIT_LOCK_ERR    9
`define QP_BIT_FALSE_CARR  8
`define QP_BIT_INVALID     7
`define QP_BIT_HALT        6
`define QP_BIT_PREM_END    5
`define QP_BIT_ANEG_DONE   4
`define QP_BIT_SIG_DET     3
`define QP_LOW_RSVD_HI     2

// Latching flag vector layout
`define QP_NFLAGS          6
`define QP_FL_SIG_LOST     0
`define QP_FL_LOCK_ERR     1
`define QP_FL_FALSE_CARR   2
`define QP_FL_INVALID      3
`define QP_FL_HALT         4
`define QP_FL_PREM_END     5
`define QP_FLAGS_RESET     6'h00

// Negotiation monitor codes
`define QP_MON_W           3
`define QP_MON_IDLE        3'h0
`define QP_MON_CONSIST_OK  3'h7

// Five-bit line symbols
`define QP_SYM_W           5
`define QP_SYM_J           5'h18
`define QP_SYM_K           5'h11
`define QP_SYM_I           5'h1F
`define QP_SYM_H           5'h04
`define QP_SYM_T           5'h0D
`define QP_SYM_R           5'h07
// One bit per five-bit code that carries a data nibble
`define QP_DATA_CODE_MASK  32'h7CFC_CE00

`endif

// [sim/quick_poll_status_chk.sv]
// Assertion checker for the quick poll status register
`timescale 1ns/1ps
module quick_poll_status_chk (
    input wire        clk_in,             // Clock
    input wire        rst_n_in,           // Reset, low
    input wire        ctl_aneg_enable_in, // Aneg enable
    input wire [4:0]  rx_symbol_in,       // Symbol
    input wire        rx_symbol_valid_in, // Symbol strobe
    input wire        mgmt_rd_in,         // Read strobe
    input wire [4:0]  mgmt_addr_in,       // Index
    input wire [15:0] mgmt_rd_data_out,   // Read data
    input wire        mgmt_rd_valid_out,  // Read valid
    input wire        rx_error_out,       // Rx error
    input wire        rx_halt_out         // Halt seen
);
default clocking cb @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
wire       hit = mgmt_rd_in && mgmt_addr_in == 5'h11;
reg  [1:0] pend;
wire [1:0] seen = pend | {rx_halt_out, rx_error_out};
////////////////////////////////////////
// Events not yet reported by a read; a pulse in the read cycle still counts
always @(posedge clk_in)
    if (!rst_n_in || hit)
        pend <= 2'h0;
    else
        pend <= seen;
////////////////////////////////////////
a_read_answer: assert property (hit |=> mgmt_rd_valid_out)
    else $error("read of status index not answered");
a_no_stray_valid: assert property (!hit |=> !mgmt_rd_valid_out)
    else $error("answer without a read");
a_low_bits_zero: assert property (mgmt_rd_valid_out |-> mgmt_rd_data_out[2:0] == 3'h0)
    else $error("low bits not zero");
a_mon_disabled: assert property (hit && !ctl_aneg_enable_in && $past(!ctl_aneg_enable_in) |=> mgmt_rd_data_out[13:11] == 3'h0)
    else $error("monitor not cleared while disabled");
a_done_disabled: assert property (hit && !ctl_aneg_enable_in && $past(!ctl_aneg_enable_in) |=> !mgmt_rd_data_out[4])
    else $error("complete shown while disabled");
a_halt_code: assert property (rx_halt_out |-> $past(rx_symbol_valid_in) && $past(rx_symbol_in) == 5'h04)
    else $error("halt pulse without halt symbol");
a_err_alone: assert property (rx_error_out |-> $past(rx_symbol_valid_in) && !rx_halt_out)
    else $error("error pulse without symbol");
a_err_flag: assert property (hit && seen[0] |=> mgmt_rd_data_out[7])
    else $error("invalid symbol flag lost");
a_halt_flag: assert property (hit && seen[1] |=> mgmt_rd_data_out[6])
    else $error("halt flag lost");
c_read: cover property (hit ##1 mgmt_rd_valid_out);
c_error: cover property (rx_error_out);
c_halt: cover property (rx_halt_out);
endmodule // quick_poll_status_chk
bind quick_poll_status quick_poll_status_chk u_chk (.clk_in, .rst_n_in, .ctl_aneg_enable_in,
    .rx_symbol_in, .rx_symbol_valid_in, .mgmt_rd_in, .mgmt_addr_in, .mgmt_rd_data_out,
    .mgmt_rd_valid_out, .rx_error_out, .rx_halt_out);

// [sim/quick_poll_status_tb.sv]
// Self-checking bench for the quick poll status register
`timescale 1ns/1ps
module quick_poll_status_tb;
reg         clk_in, rst_n_in, hw_mode_pin_in, rate_select_pin_in, duplex_select_pin_in;
reg         signal_detect_in, ctl_speed_in, ctl_duplex_in, ctl_aneg_enable_in;
reg         ctl_aneg_restart_in, aneg_complete_in, pll_locked_in, rx_symbol_valid_in, req;
reg  [2:0]  aneg_state_in;
reg  [4:0]  rx_symbol_in, req_addr;
reg  [7:0]  n_err, n_halt;
wire        mgmt_rd_in, mgmt_rd_valid_out, rx_error_out, rx_halt_out, done, got;
wire [4:0]  mgmt_addr_in;
wire [15:0] mgmt_rd_data_out, word;
integer     mismatches, n_tests, cycles;
////////////////////////////////////////
quick_poll_status dut (.clk_in, .rst_n_in, .hw_mode_pin_in, .rate_select_pin_in,
    .duplex_select_pin_in, .signal_detect_in, .ctl_speed_in, .ctl_duplex_in,
    .ctl_aneg_enable_in, .ctl_aneg_restart_in, .aneg_state_in, .aneg_complete_in,
    .pll_locked_in, .rx_symbol_in, .rx_symbol_valid_in, .mgmt_rd_in, .mgmt_addr_in,
    .mgmt_rd_data_out, .mgmt_rd_valid_out, .rx_error_out, .rx_halt_out);
sta_poller sta (.clk_in(clk_in), .rst_n_in(rst_n_in), .req_in(req), .req_addr_in(req_addr),
    .rd_valid_in(mgmt_rd_valid_out), .rd_data_in(mgmt_rd_data_out), .rd_out(mgmt_rd_in),
    .addr_out(mgmt_addr_in), .word_out(word), .got_out(got), .done_out(done));
initial
begin
    clk_in = 1'b0;
    forever #2.5 clk_in = ~clk_in;
end
always @(posedge clk_in)
begin
    cycles = cycles + 1;
    n_err <= n_err + {7'h0, rx_error_out === 1'b1};
    n_halt <= n_halt + {7'h0, rx_halt_out === 1'b1};
    if (cycles == 5000)
    begin
        mismatches = mismatches + 1;
        finish_test;
    end
end
////////////////////////////////////////
task finish_test;
    if (mismatches == 0 && n_tests > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
task chk(input [15:0] g, input [15:0] e);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
        mismatches = mismatches + 1;
        $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
endtask
task poll(input [4:0] a, input [15:0] m, input [15:0] e);
    integer i;
    req <= 1'b1;
    req_addr <= a;
    @(posedge clk_in);
    req <= 1'b0;
    for (i = 0; i < 8 && done !== 1'b1; i = i + 1)
        @(posedge clk_in);
    chk({15'h0, got}, {15'h0, a == 5'h11});
    if (a == 5'h11)
        chk(word & m, e);
endtask
task burst(input [39:0] s, input integer n);
    integer i;
    for (i = n - 1; i >= 0; i = i - 1)
    begin
        rx_symbol_in <= s[5*i +: 5];
        rx_symbol_valid_in <= 1'b1;
        @(posedge clk_in);
    end
    rx_symbol_valid_in <= 1'b0;
    rx_symbol_in <= ~s[4:0];
    repeat (3) @(posedge clk_in);
endtask
task t_selection;
    integer i;
    for (i = 0; i < 8; i = i + 1)
    begin
        hw_mode_pin_in <= i[2];
        rate_select_pin_in <= i[1];
        duplex_select_pin_in <= i[0];
        ctl_speed_in <= ~i[1];
        ctl_duplex_in <= ~i[0];
        repeat (5) @(posedge clk_in);
        poll(5'h11, 16'hC000, {i[2] ? i[1:0] : ~i[1:0], 14'h0});
    end
endtask
task t_monitor;
    ctl_aneg_enable_in <= 1'b1;
    aneg_state_in <= 3'h3;
    @(posedge clk_in);
    aneg_state_in <= 3'h1;
    @(posedge clk_in);
    aneg_state_in <= 3'h5;
    @(posedge clk_in);
    aneg_state_in <= 3'h2;
    repeat (2) @(posedge clk_in);
    poll(5'h11, 16'h3810, 16'h2800);
    poll(5'h11, 16'h3810, 16'h1000);
    aneg_state_in <= 3'h7;
    repeat (2) @(posedge clk_in);
    ctl_aneg_restart_in <= 1'b1;
    aneg_state_in <= 3'h0;
    @(posedge clk_in);
    ctl_aneg_restart_in <= 1'b0;
    poll(5'h11, 16'h3810, 16'h0000);
    // Monitor holds a nonzero code, yet completion must read as 000
    aneg_state_in <= 3'h5;
    aneg_complete_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    poll(5'h11, 16'h3810, 16'h0010);
    ctl_aneg_enable_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    poll(5'h11, 16'h3810, 16'h0000);
    aneg_complete_in <= 1'b0;
endtask
task t_receive;
    // Software mode at 100M with a live, locked receiver
    hw_mode_pin_in <= 1'b0;
    ctl_speed_in <= 1'b1;
    signal_detect_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    poll(5'h11, 16'h07F8, 16'h0008);
    burst({5'h00, 5'h18, 5'h11, 5'h1E, 5'h00, 5'h04, 5'h1F, 5'h1F}, 7);
    chk({n_halt, n_err}, 16'h0101);
    poll(5'h11, 16'h07F8, 16'h00E8);
    poll(5'h11, 16'h07F8, 16'h0008);
    burst({35'h0, 5'h1E}, 1);
    poll(5'h11, 16'h07F8, 16'h0108);
    // J followed by something other than K is a false start as well
    burst({30'h0, 5'h18, 5'h1F}, 2);
    poll(5'h11, 16'h07F8, 16'h0108);
    pll_locked_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    pll_locked_in <= 1'b1;
    poll(5'h11, 16'h07F8, 16'h0208);
    signal_detect_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    poll(5'h11, 16'h07F8, 16'h0400);
endtask
task t_reset;
    // A latched flag must not survive a reset in mid-run
    burst({35'h0, 5'h1E}, 1);
    rst_n_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    poll(5'h11, 16'h07F8, 16'h0000);
endtask
////////////////////////////////////////
initial
begin
    {mismatches, n_tests, cycles} = 0;
    {hw_mode_pin_in, rate_select_pin_in, duplex_select_pin_in, signal_detect_in} = 4'h0;
    {ctl_speed_in, ctl_duplex_in, ctl_aneg_enable_in, ctl_aneg_restart_in} = 4'h0;
    {aneg_complete_in, rx_symbol_valid_in, req, n_err, n_halt} = 19'h0;
    {aneg_state_in, rx_symbol_in, req_addr} = 13'h0;
    pll_locked_in = 1'b1;
    rst_n_in = 1'b0;
    repeat (4) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    poll(5'h11, 16'hFFFF, 16'h0000);
    poll(5'h12, 16'hFFFF, 16'h0000);
    poll(5'h10, 16'hFFFF, 16'h0000);
    t_selection;
    t_monitor;
    t_receive;
    t_reset;
    finish_test;
end
endmodule // quick_poll_status_tb

// [sim/sta_poller.sv]
// Management station model issuing single register reads
`timescale 1ns/1ps
module sta_poller (
    input  wire        clk_in,      // Clock
    input  wire        rst_n_in,    // Reset, low
    input  wire        req_in,      // Start a read
    input  wire [4:0]  req_addr_in, // Index to read
    input  wire        rd_valid_in, // Device answer
    input  wire [15:0] rd_data_in,  // Answer word
    output reg         rd_out,      // Read strobe
    output reg  [4:0]  addr_out,    // Index out
    output reg  [15:0] word_out,    // Last answer
    output reg         got_out,     // Answer seen
    output reg         done_out     // Read over
);
reg [1:0] wait_cnt;
always @(posedge clk_in)
begin
    rd_out <= 1'b0;
    done_out <= 1'b0;
    addr_out <= ~addr_out; // Index is junk outside a strobe
    if (!rst_n_in)
    begin
        wait_cnt <= 2'h0;
        got_out <= 1'b0;
        addr_out <= 5'h00;
    end
    else if (req_in)
    begin
        rd_out <= 1'b1;
        addr_out <= req_addr_in;
        got_out <= 1'b0;
        wait_cnt <= 2'h3;
    end
    else if (wait_cnt != 2'h0)
    begin
        // Gives up after three cycles, so a refused read still ends
        wait_cnt <= rd_valid_in ? 2'h0 : wait_cnt - 2'h1;
        done_out <= rd_valid_in || wait_cnt == 2'h1;
        if (rd_valid_in)
        begin
            got_out <= 1'b1;
            word_out <= rd_data_in;
        end
    end
end
endmodule // sta_poller
